//--- pkg/ext_bus_defines.vh
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH

// -------------------------------------------------------------------
// Special function register addresses
// -------------------------------------------------------------------
`define SFR_PORT0_LATCH 8'h80
`define SFR_PTR_LOW 8'h82
`define SFR_PTR_HIGH 8'h83
`define SFR_PTR_SELECT 8'h92
`define SFR_PORT2_LATCH 8'ha0

// -------------------------------------------------------------------
// Field layout and reset values
// -------------------------------------------------------------------
`define SEL_FIELD_MSB 2
`define PTR_COUNT 8
`define PTR_RESET 8'h00
`define SEL_RESET 3'h0
`define PORT_LATCH_RESET 8'hff
`define PORT0_ACCESS_FILL 8'hff
`define OE_ALL 8'hff
`define OE_NONE 8'h00
`define INT_CODE_TOP 16'h1fff

// -------------------------------------------------------------------
// Request kinds
// -------------------------------------------------------------------
`define KIND_FETCH 2'h0
`define KIND_CODE_CONST 2'h1
`define KIND_DATA_PTR 2'h2
`define KIND_DATA_REG 2'h3

// -------------------------------------------------------------------
// Bus phase timing (ns) and derived cycle counts at 5 ns clock
// -------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define ALE_WIDTH_NS 10
`define ADDR_HOLD_NS 5
`define DATA_SETUP_NS 5
`define STROBE_WIDTH_NS 20
`define DATA_HOLD_NS 5
// Whole cycles per phase, each ns figure rounded up to the clock
`define ALE_CYC 4'h2
`define ADDR_HOLD_CYC 4'h1
`define DATA_SETUP_CYC 4'h1
`define STROBE_CYC 4'h4
`define DATA_HOLD_CYC 4'h1
`define TIMER_W 4

`endif

//--- src/cycle_timer.v
`default_nettype none

// -------------------------------------------------------------------
// Phase timer: load N, expired pulses in the Nth cycle after load
// -------------------------------------------------------------------
module cycle_timer (
  input wire mclk,
  input wire rst_b,
  input wire load,
  input wire [3:0] loadValue,
  output wire expired
);

  reg [3:0] count_reg; // Cycles left in current phase

  // Down counter, parks at zero when idle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 4'h0;
    end else if (load) begin
      count_reg <= loadValue;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end
  end

  // Last cycle of the phase, so a new load lands on time
  assign expired = (count_reg == 4'h1);

endmodule // cycle_timer

`default_nettype wire

//--- src/pointer_bank.v
`default_nettype none
`include "ext_bus_defines.vh"

// -------------------------------------------------------------------
// Bank of eight 16-bit address pointers with select register
// -------------------------------------------------------------------
module pointer_bank (
  input wire mclk,
  input wire rst_b,
  input wire sfrWrite,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  input wire ptrInc,
  input wire ptrLoad,
  input wire [15:0] ptrLoadValue,
  output wire [15:0] activePointer,
  output wire [2:0] selectField
);

  reg [7:0] highByte_reg [0:`PTR_COUNT-1]; // pointer_high_byte_n
  reg [7:0] lowByte_reg [0:`PTR_COUNT-1]; // pointer_low_byte_n
  reg [2:0] select_reg; // Active pointer index
  integer i;

  // -----------------------------------------------------------------
  // Pointer storage
  // -----------------------------------------------------------------
  // Only the selected entry ever changes; the rest keep their values
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `PTR_COUNT; i = i + 1) begin
        highByte_reg[i] <= `PTR_RESET;
        lowByte_reg[i] <= `PTR_RESET;
      end
    end else if (ptrLoad) begin
      {highByte_reg[select_reg], lowByte_reg[select_reg]} <= ptrLoadValue;
    end else if (ptrInc) begin
      {highByte_reg[select_reg], lowByte_reg[select_reg]} <= activePointer + 16'h0001;
    end else if (sfrWrite && sfrAddr == `SFR_PTR_LOW) begin
      lowByte_reg[select_reg] <= sfrWdata;
    end else if (sfrWrite && sfrAddr == `SFR_PTR_HIGH) begin
      highByte_reg[select_reg] <= sfrWdata;
    end
  end

  // Select register, low three bits only
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      select_reg <= `SEL_RESET;
    end else if (sfrWrite && sfrAddr == `SFR_PTR_SELECT) begin
      select_reg <= sfrWdata[`SEL_FIELD_MSB:0];
    end
  end

  // Active pointer is the concatenation of the chosen pair
  assign activePointer = {highByte_reg[select_reg], lowByte_reg[select_reg]};
  assign selectField = select_reg;

endmodule // pointer_bank

`default_nettype wire

//--- src/ext_bus_ctrl.v
`default_nettype none
`include "ext_bus_defines.vh"

module ext_bus_ctrl (
  input wire mclk,
  input wire rst_b,
  // Core special function register port
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  output wire [7:0] sfrRdata,
  // Core pointer operations
  input wire ptrInc,
  input wire ptrLoad,
  input wire [15:0] ptrLoadValue,
  output wire [15:0] branchTarget,
  // Core access requests
  input wire reqValid,
  input wire [1:0] reqKind,
  input wire reqWrite,
  input wire [15:0] programCounter,
  input wire [7:0] regAddr,
  input wire [7:0] reqWdata,
  output wire busBusy,
  output wire busDone,
  output wire busExternal,
  output wire [7:0] busRdata,
  // External pins
  input wire externalAccessN,
  input wire [7:0] muxedAddrDataPortIn,
  output wire [7:0] muxedAddrDataPortOut,
  output wire [7:0] muxedAddrDataPortOe,
  output wire [7:0] highAddrPortOut,
  output wire [7:0] highAddrPortOe,
  output wire addrLatchEnable,
  output wire programStoreStrobeN,
  output wire readStrobeN,
  output wire writeStrobeN
);

  // -----------------------------------------------------------------
  // Bus cycle states
  // -----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0; // Ports show latches
  localparam [2:0] ST_ADDR = 3'h1; // Address out, latch enable high
  localparam [2:0] ST_AHOLD = 3'h2; // Address held after latch enable
  localparam [2:0] ST_DSETUP = 3'h3; // Write data before strobe
  localparam [2:0] ST_STROBE = 3'h4; // Strobe active
  localparam [2:0] ST_DHOLD = 3'h5; // Data held after strobe

  reg [2:0] state_reg; // Current phase
  reg [2:0] state_next; // Next phase
  reg [1:0] kind_reg; // Kind of running access
  reg write_reg; // Running access is a write
  reg [7:0] wdata_reg; // Data to write
  reg [15:0] addr_reg; // Address of running access
  reg use16_reg; // Port 2 carries high address
  reg [7:0] port0Latch_reg; // Port 0 special function latch
  reg [7:0] port2Latch_reg; // Port 2 special function latch
  reg [7:0] p0Out_reg; // Port 0 pin drive value
  reg [7:0] p0Oe_reg; // Port 0 pin enables
  reg [7:0] p2Out_reg; // Port 2 pin drive value
  reg ale_reg; // Address latch enable
  reg psenN_reg; // Program store strobe
  reg rdN_reg; // Data read strobe
  reg wrN_reg; // Data write strobe
  reg done_reg; // One-cycle completion pulse
  reg external_reg; // Last access went to pins
  reg [7:0] rdata_reg; // Captured read data
  reg [7:0] sfrRdata_reg; // Register read data
  reg busy_reg; // Access in progress
  reg [15:0] branch_reg; // Registered jump target

  reg timerLoad; // Start a phase
  reg [3:0] timerValue; // Length of next phase
  wire timerExpired; // Current phase over
  wire [15:0] activePointer; // Selected pointer
  wire [2:0] selectField; // Select register contents
  wire fetchExternal; // Fetch must go off chip
  wire [15:0] reqAddr; // Address of incoming request
  wire reqUse16; // Incoming request uses port 2 for address
  wire startAccess; // Take an off-chip request now

  // -----------------------------------------------------------------
  // Submodules
  // -----------------------------------------------------------------
  pointer_bank u_pointer_bank (
    .mclk(mclk),
    .rst_b(rst_b),
    .sfrWrite(sfrWrite),
    .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata),
    .ptrInc(ptrInc),
    .ptrLoad(ptrLoad),
    .ptrLoadValue(ptrLoadValue),
    .activePointer(activePointer),
    .selectField(selectField)
  );

  cycle_timer u_cycle_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(timerExpired)
  );

  // -----------------------------------------------------------------
  // Request decode
  // -----------------------------------------------------------------
  // Code above the internal range or forced external goes to the pins
  assign fetchExternal = !externalAccessN || (programCounter > `INT_CODE_TOP);

  // Fetch uses the PC, everything else but register indirect the pointer
  assign reqAddr = (reqKind == `KIND_FETCH) ? programCounter :
                   (reqKind == `KIND_DATA_REG) ? {8'h00, regAddr} :
                   activePointer;
  assign reqUse16 = (reqKind != `KIND_DATA_REG);

  // Internal fetches finish at once and never touch the pins
  assign startAccess = reqValid && (state_reg == ST_IDLE) &&
                       ((reqKind != `KIND_FETCH) || fetchExternal);

  // -----------------------------------------------------------------
  // Next-state and phase length
  // -----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    timerLoad = 1'b0;
    timerValue = 4'h0;
    case (state_reg)
      ST_IDLE: begin
        if (startAccess) begin
          state_next = ST_ADDR;
          timerLoad = 1'b1;
          timerValue = `ALE_CYC;
        end
      end
      ST_ADDR: begin
        if (timerExpired) begin
          state_next = ST_AHOLD;
          timerLoad = 1'b1;
          timerValue = `ADDR_HOLD_CYC;
        end
      end
      ST_AHOLD: begin
        if (timerExpired) begin
          state_next = ST_DSETUP;
          timerLoad = 1'b1;
          timerValue = `DATA_SETUP_CYC;
        end
      end
      ST_DSETUP: begin
        if (timerExpired) begin
          state_next = ST_STROBE;
          timerLoad = 1'b1;
          timerValue = `STROBE_CYC;
        end
      end
      ST_STROBE: begin
        if (timerExpired) begin
          state_next = ST_DHOLD;
          timerLoad = 1'b1;
          timerValue = `DATA_HOLD_CYC;
        end
      end
      ST_DHOLD: begin
        if (timerExpired) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Access bookkeeping
  // -----------------------------------------------------------------
  // Request fields captured once so the core may move on
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      kind_reg <= `KIND_FETCH;
      write_reg <= 1'b0;
      wdata_reg <= 8'h00;
      addr_reg <= 16'h0000;
      use16_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != ST_IDLE);
      if (startAccess) begin
        kind_reg <= reqKind;
        write_reg <= reqWrite && (reqKind[1] == 1'b1); // Fetches never write
        wdata_reg <= reqWdata;
        addr_reg <= reqAddr;
        use16_reg <= reqUse16;
      end
    end
  end

  // -----------------------------------------------------------------
  // Port latches
  // -----------------------------------------------------------------
  // Access fill wins over a software write in the same cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port0Latch_reg <= `PORT_LATCH_RESET;
    end else if (startAccess) begin
      port0Latch_reg <= `PORT0_ACCESS_FILL;
    end else if (sfrWrite && sfrAddr == `SFR_PORT0_LATCH) begin
      port0Latch_reg <= sfrWdata;
    end
  end

  // Port 2 latch only ever changes by software
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port2Latch_reg <= `PORT_LATCH_RESET;
    end else if (sfrWrite && sfrAddr == `SFR_PORT2_LATCH) begin
      port2Latch_reg <= sfrWdata;
    end
  end

  // -----------------------------------------------------------------
  // Pin drive
  // -----------------------------------------------------------------
  // Idle port 0 is open drain: enable only where the latch holds zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p0Out_reg <= 8'h00;
      p0Oe_reg <= `OE_NONE;
      p2Out_reg <= `PORT_LATCH_RESET;
      ale_reg <= 1'b0;
    end else begin
      case (state_next)
        ST_ADDR, ST_AHOLD: begin
          p0Out_reg <= (state_reg == ST_IDLE) ? reqAddr[7:0] : addr_reg[7:0];
          p0Oe_reg <= `OE_ALL;
          ale_reg <= (state_next == ST_ADDR);
        end
        ST_DSETUP, ST_STROBE, ST_DHOLD: begin
          // Write data before, during and after the strobe; reads release
          p0Out_reg <= wdata_reg;
          p0Oe_reg <= write_reg ? `OE_ALL : `OE_NONE;
          ale_reg <= 1'b0;
        end
        default: begin
          p0Out_reg <= 8'h00;
          p0Oe_reg <= ~port0Latch_reg;
          ale_reg <= 1'b0;
        end
      endcase
      // High byte held from address phase to end of data hold
      if (state_next != ST_IDLE) begin
        if (state_reg == ST_IDLE) begin
          p2Out_reg <= reqUse16 ? reqAddr[15:8] : port2Latch_reg;
        end else begin
          p2Out_reg <= use16_reg ? addr_reg[15:8] : port2Latch_reg;
        end
      end else begin
        p2Out_reg <= port2Latch_reg;
      end
    end
  end

  // Strobes: program store for code, read/write for data
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      psenN_reg <= 1'b1;
      rdN_reg <= 1'b1;
      wrN_reg <= 1'b1;
    end else begin
      psenN_reg <= !((state_next == ST_STROBE) && !kind_reg[1]);
      rdN_reg <= !((state_next == ST_STROBE) && kind_reg[1] && !write_reg);
      wrN_reg <= !((state_next == ST_STROBE) && kind_reg[1] && write_reg);
    end
  end

  // -----------------------------------------------------------------
  // Completion and read data
  // -----------------------------------------------------------------
  // Sample while the strobe is still low, in its last cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
      external_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == ST_STROBE && timerExpired && !write_reg) begin
        rdata_reg <= muxedAddrDataPortIn;
      end
      if (state_reg == ST_DHOLD && timerExpired) begin
        done_reg <= 1'b1;
        external_reg <= 1'b1;
      end else if (reqValid && state_reg == ST_IDLE && !startAccess) begin
        // Internal fetch: no pin activity, served by on-chip code
        done_reg <= 1'b1;
        external_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Register reads and branch target
  // -----------------------------------------------------------------
  // Unmapped addresses read zero; select reads upper bits as zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdata_reg <= 8'h00;
      branch_reg <= 16'h0000;
    end else begin
      branch_reg <= activePointer;
      if (sfrRead) begin
        case (sfrAddr)
          `SFR_PTR_LOW: sfrRdata_reg <= activePointer[7:0];
          `SFR_PTR_HIGH: sfrRdata_reg <= activePointer[15:8];
          `SFR_PTR_SELECT: sfrRdata_reg <= {5'h00, selectField};
          `SFR_PORT0_LATCH: sfrRdata_reg <= port0Latch_reg;
          `SFR_PORT2_LATCH: sfrRdata_reg <= port2Latch_reg;
          default: sfrRdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign sfrRdata = sfrRdata_reg;
  assign branchTarget = branch_reg;
  assign busBusy = busy_reg;
  assign busDone = done_reg;
  assign busExternal = external_reg;
  assign busRdata = rdata_reg;
  assign muxedAddrDataPortOut = p0Out_reg;
  assign muxedAddrDataPortOe = p0Oe_reg;
  assign highAddrPortOut = p2Out_reg;
  // Port 2 is push-pull here, so ones stay strongly driven
  assign highAddrPortOe = `OE_ALL;
  assign addrLatchEnable = ale_reg;
  assign programStoreStrobeN = psenN_reg;
  assign readStrobeN = rdN_reg;
  assign writeStrobeN = wrN_reg;

endmodule // ext_bus_ctrl

`default_nettype wire

//--- sim/ext_bus_ctrl_assertions.sv
`default_nettype none
`include "ext_bus_defines.vh"

// ----------------------------------------
// Pin protocol checker
// ----------------------------------------
module ext_bus_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire logic [1:0] reqKind,
  input wire logic [15:0] programCounter,
  input wire logic externalAccessN,
  input wire logic busBusy,
  input wire logic busDone,
  input wire logic busExternal,
  input wire logic [7:0] muxedAddrDataPortOut,
  input wire logic [7:0] muxedAddrDataPortOe,
  input wire logic [7:0] highAddrPortOut,
  input wire logic [7:0] highAddrPortOe,
  input wire logic addrLatchEnable,
  input wire logic programStoreStrobeN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Any strobe active
  wire anyStb = !programStoreStrobeN || !readStrobeN || !writeStrobeN;
  // Fetch request forced to the pins by externalAccessN low
  wire extFetch = reqValid && !busBusy && reqKind == `KIND_FETCH && !externalAccessN;
  // Fetch served from inside
  wire intFetch = reqValid && !busBusy && reqKind == `KIND_FETCH && externalAccessN
    && programCounter <= `INT_CODE_TOP;

  a_program_store_strobe_n_alone: assert property (!programStoreStrobeN |-> readStrobeN && writeStrobeN)
    else $error("program strobe overlaps data strobe");
  a_rd_wr_excl: assert property (!readStrobeN |-> writeStrobeN)
    else $error("read and write strobes together");
  a_p2_held: assert property (anyStb && $past(anyStb) |-> $stable(highAddrPortOut))
    else $error("high address moved under strobe");
  a_p2_strong: assert property (highAddrPortOe == `OE_ALL)
    else $error("high address port not driven");
  a_wr_driven: assert property (!writeStrobeN |-> muxedAddrDataPortOe == `OE_ALL
    && $stable(muxedAddrDataPortOut)) else $error("write data not held under strobe");
  a_wr_hold: assert property ($rose(writeStrobeN) |-> muxedAddrDataPortOe == `OE_ALL
    && $stable(muxedAddrDataPortOut)) else $error("write data dropped at release");
  a_rd_release: assert property (!readStrobeN || !programStoreStrobeN
    |-> muxedAddrDataPortOe == `OE_NONE) else $error("port 0 driven during read");
  a_ale_addr: assert property (addrLatchEnable |-> muxedAddrDataPortOe == `OE_ALL && !anyStb)
    else $error("address latch pulse without address");
  a_ext_fetch: assert property (extFetch |=> addrLatchEnable && busBusy
    && {highAddrPortOut, muxedAddrDataPortOut} == $past(programCounter))
    else $error("external fetch address wrong");
  a_int_fetch: assert property (intFetch |=> !addrLatchEnable ##[0:1] (busDone && !busExternal))
    else $error("internal fetch misrouted");

  // Main scenarios reached
  c_fetch: cover property (!programStoreStrobeN);
  c_read: cover property (!readStrobeN);
  c_write: cover property ($rose(writeStrobeN));
endmodule // ext_bus_checker

bind ext_bus_ctrl ext_bus_checker u_ext_bus_checker (.mclk(mclk), .rst_b(rst_b),
  .reqValid(reqValid), .reqKind(reqKind), .programCounter(programCounter),
  .externalAccessN(externalAccessN), .busBusy(busBusy), .busDone(busDone),
  .busExternal(busExternal), .muxedAddrDataPortOut(muxedAddrDataPortOut),
  .muxedAddrDataPortOe(muxedAddrDataPortOe), .highAddrPortOut(highAddrPortOut),
  .highAddrPortOe(highAddrPortOe), .addrLatchEnable(addrLatchEnable),
  .programStoreStrobeN(programStoreStrobeN), .readStrobeN(readStrobeN),
  .writeStrobeN(writeStrobeN));
`default_nettype wire

//--- sim/ext_memory_model.sv
`default_nettype none

// ----------------------------------------
// External code and data memory
// ----------------------------------------
module ext_memory_model (
  input wire logic mclk,
  input wire logic slowMode,
  input wire logic addrLatchEnable,
  input wire logic programStoreStrobeN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] busOut,
  input wire logic [7:0] busOe,
  input wire logic [7:0] highAddr,
  output logic [7:0] busIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dataMem [0:65535]; // Data space
  logic [7:0] lowAddr = 8'h00; // External address latch
  logic [7:0] junk = 8'h00; // Floating bus pattern
  logic seen = 1'b0; // Strobe seen one edge
  logic wrPrev = 1'b1; // Write strobe last edge
  wire [15:0] addr = {highAddr, lowAddr};
  wire codeRd = !programStoreStrobeN;
  wire [7:0] rdByte = codeRd ? (addr[15:8] ^ addr[7:0] ^ 8'ha5) : dataMem[addr];
  // Slow mode withholds data for the first strobe cycle
  wire drive = (codeRd || !readStrobeN) && (!slowMode || seen);
  // Pin level: device wins where it drives, else memory or junk
  assign busIn = (busOe & busOut) | (~busOe & (drive ? rdByte : junk));

  // Known data contents
  initial begin
    for (int j = 0; j < 65536; j++) dataMem[j] = j[7:0] ^ 8'h3c ^ {j[11:8], j[15:12]};
  end

  // Latch, strobe tracking and write capture
  always @(posedge mclk) begin
    junk <= junk + 8'h55;
    if (addrLatchEnable) lowAddr <= busOut;
    seen <= codeRd || !readStrobeN;
    wrPrev <= writeStrobeN;
    // Capture at release, so held data is required
    if (!wrPrev && writeStrobeN) dataMem[addr] <= busOut;
  end
endmodule // ext_memory_model
`default_nettype wire

//--- sim/tb_ext_bus_ctrl.sv
`default_nettype none

// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_ext_bus_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0; // Held low at start
  logic sfrWrite = 1'b0, sfrRead = 1'b0, ptrInc = 1'b0;
  logic ptrLoad = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic externalAccessN = 1'b1, slowMode = 1'b0, rdPend = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, regAddr = 8'h00, reqWdata = 8'h00, d;
  logic [1:0] reqKind = 2'h0;
  logic [15:0] ptrLoadValue = 16'h0000, programCounter = 16'h0000;
  wire [7:0] sfrRdata, busRdata, p0In, p0Out, p0Oe, p2Out;
  wire [15:0] branchTarget;
  wire busBusy, busDone, busExternal, ale, psenN, rdN, wrN;
  logic [17:0] notes[$]; // Expected {mask, value}
  logic [15:0] ptrs [0:7]; // Pointer shadow
  int errors = 0, n_tests = 0, i;

  always #2.5 mclk = ~mclk;

  ext_bus_ctrl u_ext_bus_ctrl (.mclk(mclk), .rst_b(rst_b), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .ptrInc(ptrInc), .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue),
    .branchTarget(branchTarget), .reqValid(reqValid), .reqKind(reqKind), .reqWrite(reqWrite),
    .programCounter(programCounter), .regAddr(regAddr), .reqWdata(reqWdata),
    .busBusy(busBusy), .busDone(busDone), .busExternal(busExternal), .busRdata(busRdata),
    .externalAccessN(externalAccessN), .muxedAddrDataPortIn(p0In),
    .muxedAddrDataPortOut(p0Out), .muxedAddrDataPortOe(p0Oe), .highAddrPortOut(p2Out),
    .highAddrPortOe(), .addrLatchEnable(ale), .programStoreStrobeN(psenN),
    .readStrobeN(rdN), .writeStrobeN(wrN));

  ext_memory_model u_ext_memory_model (.mclk(mclk), .slowMode(slowMode),
    .addrLatchEnable(ale), .programStoreStrobeN(psenN), .readStrobeN(rdN),
    .writeStrobeN(wrN), .busOut(p0Out), .busOe(p0Oe), .highAddr(p2Out), .busIn(p0In));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task end_sim;
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task report(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Oldest note against a result; empty queue is a stray result
  task cmp(input logic [8:0] got);
    logic [17:0] n;
    if (notes.size() == 0) begin
      report({7'h0, got}, 16'hffff);
    end else begin
      n = notes.pop_front();
      report({7'h0, got & n[17:9]}, {7'h0, n[8:0]});
    end
  endtask

  // Result watcher
  always @(posedge mclk) begin
    if (busDone === 1'b1) cmp({busExternal, busRdata});
    if (rdPend) cmp({1'b0, sfrRdata});
    rdPend <= sfrRead;
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task tick;
    @(posedge mclk);
    #1;
  endtask

  task sfr_wr(input logic [7:0] a, input logic [7:0] v);
    sfrAddr = a;
    sfrWdata = v;
    sfrWrite = 1'b1;
    tick;
    sfrWrite = 1'b0;
    tick;
  endtask

  task sfr_rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a;
    sfrRead = 1'b1;
    notes.push_back({9'h0ff, 1'b0, e});
    tick;
    sfrRead = 1'b0;
    tick;
  endtask

  // One access, request held for one cycle, bounded wait for done
  task acc(input logic [1:0] k, input logic w, input logic [15:0] pc, input logic [7:0] ra,
      input logic [7:0] wd, input logic [17:0] note);
    int n;
    n = 0;
    reqKind = k;
    reqWrite = w;
    programCounter = pc;
    regAddr = ra;
    reqWdata = wd;
    reqValid = 1'b1;
    notes.push_back(note);
    tick;
    reqValid = 1'b0;
    while (busDone !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    // Idle edge so the next request is raised a cycle after release
    tick;
    if (n == 40) begin
      errors++;
      end_sim;
    end
  endtask

  function logic [7:0] codeOf(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'ha5;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9bf6));
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    // Reset contents and an unmapped place
    sfr_rd(8'h92, 8'h00);
    sfr_rd(8'h82, 8'h00);
    sfr_rd(8'ha0, 8'hff);
    sfr_rd(8'h81, 8'h00);
    // Load all eight pointers byte by byte
    for (i = 0; i < 8; i++) begin
      ptrs[i] = 16'($urandom) | 16'h8000;
      sfr_wr(8'h92, 8'(i));
      sfr_wr(8'h82, ptrs[i][7:0]);
      sfr_wr(8'h83, ptrs[i][15:8]);
    end
    // Select each, upper select bits set, then use it on the bus
    for (i = 0; i < 8; i++) begin
      sfr_wr(8'h92, 8'(i) | 8'hf8);
      sfr_rd(8'h92, 8'(i));
      sfr_rd(8'h83, ptrs[i][15:8]);
      sfr_rd(8'h82, ptrs[i][7:0]);
      report(branchTarget, ptrs[i]);
      slowMode = i[0];
      d = 8'($urandom);
      acc(2'h1, 1'b0, 16'h0, 8'h0, 8'h0, {9'h1ff, 1'b1, codeOf(ptrs[i])});
      acc(2'h2, 1'b1, 16'h0, 8'h0, d, {9'h100, 9'h100});
      acc(2'h2, 1'b0, 16'h0, 8'h0, 8'h0, {9'h1ff, 1'b1, d});
    end
    // Paged register access and latch fill
    sfr_wr(8'ha0, 8'h3a);
    sfr_wr(8'h80, 8'h5a);
    sfr_rd(8'h80, 8'h5a);
    d = 8'($urandom);
    acc(2'h3, 1'b1, 16'h0, 8'hc5, d, {9'h100, 9'h100});
    sfr_rd(8'h80, 8'hff);
    acc(2'h3, 1'b0, 16'h0, 8'h17, 8'h0, {9'h1ff, 1'b1, 8'h17 ^ 8'h3c ^ 8'ha3});
    sfr_wr(8'h92, 8'h05);
    sfr_wr(8'h83, 8'h3a);
    sfr_wr(8'h82, 8'hc5);
    acc(2'h2, 1'b0, 16'h0, 8'h0, 8'h0, {9'h1ff, 1'b1, d});
    sfr_rd(8'ha0, 8'h3a);
    // Program fetches around the internal boundary
    acc(2'h0, 1'b0, 16'h1fff, 8'h0, 8'h0, {9'h100, 9'h000});
    acc(2'h0, 1'b0, 16'h2000, 8'h0, 8'h0, {9'h1ff, 1'b1, codeOf(16'h2000)});
    externalAccessN = 1'b0;
    acc(2'h0, 1'b0, 16'h0123, 8'h0, 8'h0, {9'h1ff, 1'b1, codeOf(16'h0123)});
    externalAccessN = 1'b1;
    // Load then increment with carry, only active pointer moves
    ptrLoadValue = 16'h40ff;
    ptrLoad = 1'b1;
    tick;
    ptrLoad = 1'b0;
    ptrInc = 1'b1;
    tick;
    ptrInc = 1'b0;
    sfr_rd(8'h83, 8'h41);
    sfr_rd(8'h82, 8'h00);
    sfr_wr(8'h92, 8'h04);
    sfr_rd(8'h82, ptrs[4][7:0]);
    tick;
    tick;
    end_sim;
  end
endmodule // tb_ext_bus_ctrl
`default_nettype wire
